// File: design/hpd_pkg.sv
package hpd_pkg;

	// ------------------------------------------------------------
	// timing base
	// ------------------------------------------------------------
	localparam int unsigned        CLK_PERIOD_NS   = 100;
	localparam int unsigned        TICK_PS         = 5000;
	localparam int unsigned        FINE_STEP_FS    = 78125;
	localparam int unsigned        PERIOD_STEP_NS  = 20;
	localparam int unsigned        TICK_NS         = 5;
	localparam int unsigned        DT_STEP_PS      = 1250;
	localparam int unsigned        MAX_FREQ_KHZ    = 2000;

	// ------------------------------------------------------------
	// widths and derived counts
	// ------------------------------------------------------------
	localparam int unsigned        COARSE_W        = 11;
	localparam int unsigned        FINE_W          = 6;
	localparam int unsigned        DT_W            = 8;
	localparam int unsigned        DT_EL_W         = 10;
	localparam int unsigned        MEAS_W          = 12;
	localparam int unsigned        SYNC_PINS       = 8;
	localparam int unsigned        STEP_TICKS      = PERIOD_STEP_NS / TICK_NS;
	localparam int unsigned        STEP_LSBS       = $clog2(STEP_TICKS);
	localparam int unsigned        MIN_PER_NS      = 1000000 / MAX_FREQ_KHZ;
	localparam logic [COARSE_W-1:0] MIN_PER_TICKS  = COARSE_W'(MIN_PER_NS / TICK_NS);
	localparam logic [DT_EL_W-1:0] DT_PER_TICK     = DT_EL_W'(TICK_PS / DT_STEP_PS);
	localparam logic [DT_EL_W-1:0] DT_EL_MAX       = 10'h3ff;
	localparam logic [MEAS_W-1:0]  MEAS_MAX        = 12'hfff;

	// ------------------------------------------------------------
	// sync lock windows, as right shifts of the period, and acquisition edge counts
	// ------------------------------------------------------------
	localparam int unsigned        ACQ_SHIFT       = 4;
	localparam int unsigned        HOLD_SHIFT      = 3;
	localparam int unsigned        TMO_SHIFT       = 2;
	localparam logic [1:0]         ACQ_GOOD        = 2'h2;
	localparam logic [2:0]         ACQ_BAD         = 3'h4;

	// ------------------------------------------------------------
	// carriers and states
	// ------------------------------------------------------------
	typedef struct packed {
		logic [DT_W-1:0] rise;
		logic [DT_W-1:0] fall;
	} hpd_dt_cfg_t;

	typedef struct packed {
		logic [COARSE_W-1:0] coarse;
		logic [FINE_W-1:0]   fine;
	} hpd_edge_t;

	typedef enum logic [2:0] {
		ST_CFG  = 3'b001,
		ST_IDLE = 3'b010,
		ST_RUN  = 3'b100
	} hpd_out_st_t;

	typedef enum logic [2:0] {
		SY_OFF  = 3'b001,
		SY_ACQ  = 3'b010,
		SY_LOCK = 3'b100
	} hpd_sync_st_t;

endpackage

// File: design/hpd_dead_time.sv
`timescale 1ns/1ps
module hpd_dead_time
	import hpd_pkg::*;
(
	// clock and reset
	input  wire logic                 i_mclk,
	input  wire logic                 i_rstn,
	// raw pulse and delays
	input  wire logic                 i_raw,
	input  wire hpd_pkg::hpd_dt_cfg_t i_cfg,
	// delayed pulse
	output logic                      o_out
);
	import hpd_pkg::*;

	logic                 raw_d_r;
	logic                 raw_d_nxt;
	logic [DT_EL_W-1:0]   el_r;
	logic [DT_EL_W-1:0]   el_nxt;
	hpd_dt_cfg_t          cfg_r;
	hpd_dt_cfg_t          cfg_nxt;
	logic                 out_r;
	logic                 out_nxt;

	// ------------------------------------------------------------
	// elapsed time since last raw edge, in dead-time steps
	// ------------------------------------------------------------
	always_comb begin
		raw_d_nxt = i_raw;
		cfg_nxt   = cfg_r;
		if (i_raw != raw_d_r) begin
			el_nxt  = '0;
			cfg_nxt = i_cfg;
		end else if (el_r > DT_EL_MAX - DT_PER_TICK) begin
			el_nxt = DT_EL_MAX;
		end else begin
			el_nxt = el_r + DT_PER_TICK;
		end
		if (i_raw) begin
			out_nxt = out_r | (el_nxt >= DT_EL_W'(cfg_nxt.rise));
		end else begin
			out_nxt = out_r & (el_nxt < DT_EL_W'(cfg_nxt.fall));
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			raw_d_r <= 1'b0;
			el_r    <= '0;
			cfg_r   <= '0;
			out_r   <= 1'b0;
		end else begin
			raw_d_r <= raw_d_nxt;
			el_r    <= el_nxt;
			cfg_r   <= cfg_nxt;
			out_r   <= out_nxt;
		end
	end

	assign o_out = out_r;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_rise_needs_raw;
		@(posedge i_mclk) disable iff (!i_rstn)
		$rose(out_r) |-> $past(i_raw);
	endproperty
	a_rise_needs_raw: assert property (p_rise_needs_raw)
		else $error("delayed output rose without raw high");

	property p_zero_rise;
		@(posedge i_mclk) disable iff (!i_rstn)
		($rose(i_raw) && i_cfg.rise == '0) |=> out_r;
	endproperty
	a_zero_rise: assert property (p_zero_rise)
		else $error("zero rise delay not honoured in one cycle");

	property p_rise_delay_held;
		@(posedge i_mclk) disable iff (!i_rstn)
		($rose(i_raw) && i_cfg.rise > 8'h04 && !out_r) |=> !out_r [*2];
	endproperty
	a_rise_delay_held: assert property (p_rise_delay_held)
		else $error("rise delay shorter than programmed");

endmodule

// File: design/hpd_pwm_top.sv
`timescale 1ns/1ps
// Contract
// - period counted by 11-bit coarse counter of 5 ns ticks, at most 2044.
// - duty edge of the main output given a 6-bit fine code on o_fine_main, 78.125 ps steps.
// - period down to 2 MHz, quantised in 20 ns steps.
// - requested period truncated down to a 20 ns multiple, raised to the 2 MHz minimum period if below it.
// - both outputs off between one switch off and partner on.
// - rising edge of each output delayed 0 to 318.75 ns, 1.25 ns steps.
// - falling edge of each output separately adjustable.
// - dead-time changes accepted while running, no stop needed.
// - outputs high impedance during reset, configuration and initialisation.
// - after configuration, loop-assigned outputs driven low until switching.
// - multipurpose sync pin works as clock input or clock output.
// - sync input may come from any general-purpose pin.
// - several sync inputs selected: lowest pin number wins.
// - received sync routed to a selectable control loop.
// - lock acquired only within 6.25 percent of programmed frequency.
// - once locked, stays locked within 12.5 percent drift.
// - sync output set when ramp passes threshold, giving its phase.
// - lock status shown; fault raised when sync fails.
// - the main output has an inverted companion, both dead-timed.
module hpd_pwm_top
	import hpd_pkg::*;
(
	// clock and reset
	input  wire logic                 i_mclk,
	input  wire logic                 i_rstn,
	// firmware control
	input  wire logic                 i_cfg_done,
	input  wire logic                 i_loop_assigned,
	input  wire logic                 i_run,
	input  wire logic [10:0]          i_period_ticks,
	input  wire hpd_pkg::hpd_edge_t   i_duty,
	input  wire hpd_pkg::hpd_dt_cfg_t i_dt_main,
	input  wire hpd_pkg::hpd_dt_cfg_t i_dt_comp,
	// sync configuration
	input  wire logic                 i_sync_en,
	input  wire logic                 i_sync_dir_out,
	input  wire logic [7:0]           i_sync_pin_sel,
	input  wire logic                 i_sync_loop_sel,
	input  wire logic [10:0]          i_sync_phase,
	input  wire logic                 i_sync_fault_clr,
	// sync pins, index 0 is the multipurpose sync pin
	input  wire logic [7:0]           i_sync_pins,
	output logic                      o_multipurpose_sync_pin_out,
	output logic                      o_multipurpose_sync_pin_oe_n,
	// gate drive pins
	output logic                      o_pwm_main,
	output logic                      o_pwm_main_oe_n,
	output logic                      o_pwm_comp,
	output logic                      o_pwm_comp_oe_n,
	output logic [5:0]                o_fine_main,
	// status
	output logic                      o_sync_locked,
	output logic                      o_sync_fault,
	output logic [1:0]                o_sync_evt
);
	import hpd_pkg::*;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic in_win(input logic [MEAS_W-1:0] m,
	                                input logic [COARSE_W-1:0] p,
	                                input logic [COARSE_W-1:0] tol);
		logic [MEAS_W-1:0] pe;
		logic [MEAS_W-1:0] d;
		pe = MEAS_W'(p);
		d  = (m > pe) ? (m - pe) : (pe - m);
		return d <= MEAS_W'(tol);
	endfunction

	function automatic logic [COARSE_W-1:0] eff_period(input logic [COARSE_W-1:0] req);
		logic [COARSE_W-1:0] t;
		t = {req[COARSE_W-1:STEP_LSBS], STEP_LSBS'(0)};
		return (t < MIN_PER_TICKS) ? MIN_PER_TICKS : t;
	endfunction

	// ------------------------------------------------------------
	// output state
	// ------------------------------------------------------------
	hpd_out_st_t         st_r;
	hpd_out_st_t         st_nxt;
	logic                oe_n_r;
	logic                oe_n_nxt;

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			ST_CFG: begin
				if (i_cfg_done) st_nxt = ST_IDLE;
			end
			ST_IDLE: begin
				if (i_run && i_loop_assigned) st_nxt = ST_RUN;
			end
			ST_RUN: begin
				if (!i_run || !i_loop_assigned) st_nxt = ST_IDLE;
			end
			default: st_nxt = ST_CFG;
		endcase
		if (!i_cfg_done) st_nxt = ST_CFG;
		oe_n_nxt = !((st_nxt != ST_CFG) && i_loop_assigned);
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			st_r   <= ST_CFG;
			oe_n_r <= 1'b1;
		end else begin
			st_r   <= st_nxt;
			oe_n_r <= oe_n_nxt;
		end
	end

	// ------------------------------------------------------------
	// coarse period counter and pulse compare
	// ------------------------------------------------------------
	logic [COARSE_W-1:0] cnt_r;
	logic [COARSE_W-1:0] cnt_nxt;
	logic [COARSE_W-1:0] per_r;
	logic [COARSE_W-1:0] per_nxt;
	hpd_edge_t           duty_r;
	hpd_edge_t           duty_nxt;
	logic                raw_r;
	logic                raw_nxt;
	logic                resync;
	logic                wrap;

	always_comb begin
		wrap     = (cnt_r >= per_r - 11'h001);
		cnt_nxt  = cnt_r + 11'h001;
		per_nxt  = per_r;
		duty_nxt = duty_r;
		if (st_r != ST_RUN) begin
			cnt_nxt  = '0;
			per_nxt  = eff_period(i_period_ticks);
			duty_nxt = i_duty;
		end else if (wrap || resync) begin
			cnt_nxt  = '0;
			per_nxt  = eff_period(i_period_ticks);
			duty_nxt = i_duty;
		end
		raw_nxt = (st_nxt == ST_RUN) && (cnt_nxt < duty_nxt.coarse);
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_r  <= '0;
			per_r  <= MIN_PER_TICKS;
			duty_r <= '0;
			raw_r  <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			per_r  <= per_nxt;
			duty_r <= duty_nxt;
			raw_r  <= raw_nxt;
		end
	end

	// ------------------------------------------------------------
	// dead time on the pulse and its inverted companion
	// ------------------------------------------------------------
	logic                dt_main;
	logic                dt_comp;
	logic                comp_raw;

	assign comp_raw = (st_r == ST_RUN) && !raw_r;

	hpd_dead_time u_dt_main (
		.i_mclk (i_mclk),
		.i_rstn (i_rstn),
		.i_raw  (raw_r),
		.i_cfg  (i_dt_main),
		.o_out  (dt_main)
	);

	hpd_dead_time u_dt_comp (
		.i_mclk (i_mclk),
		.i_rstn (i_rstn),
		.i_raw  (comp_raw),
		.i_cfg  (i_dt_comp),
		.o_out  (dt_comp)
	);

	assign o_pwm_main      = dt_main && !oe_n_r;
	assign o_pwm_comp      = dt_comp && !oe_n_r && !dt_main;
	assign o_pwm_main_oe_n = oe_n_r;
	assign o_pwm_comp_oe_n = oe_n_r;
	assign o_fine_main     = duty_r.fine;

	// ------------------------------------------------------------
	// sync input capture and pin priority
	// ------------------------------------------------------------
	logic [7:0]          pin_s1_r;
	logic [7:0]          pin_s2_r;
	logic                sel_d_r;
	logic                sel_lvl;
	logic                sync_in_act;
	logic                sync_edge;

	always_comb begin
		sel_lvl = 1'b0;
		for (int i = SYNC_PINS - 1; i >= 0; i--) begin
			if (i_sync_pin_sel[i]) sel_lvl = pin_s2_r[i];
		end
	end

	assign sync_in_act = i_sync_en && !i_sync_dir_out;
	assign sync_edge   = sync_in_act && sel_lvl && !sel_d_r;

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			pin_s1_r <= '0;
			pin_s2_r <= '0;
			sel_d_r  <= 1'b0;
		end else begin
			pin_s1_r <= i_sync_pins;
			pin_s2_r <= pin_s1_r;
			sel_d_r  <= sel_lvl;
		end
	end

	// ------------------------------------------------------------
	// lock tracking
	// ------------------------------------------------------------
	hpd_sync_st_t        sy_r;
	hpd_sync_st_t        sy_nxt;
	logic [MEAS_W-1:0]   meas_r;
	logic [MEAS_W-1:0]   meas_nxt;
	logic [1:0]          good_r;
	logic [1:0]          good_nxt;
	logic [2:0]          bad_r;
	logic [2:0]          bad_nxt;
	logic                fault_r;
	logic                fault_nxt;
	logic [1:0]          evt_r;
	logic [1:0]          evt_nxt;
	logic [COARSE_W-1:0] tol_acq;
	logic [COARSE_W-1:0] tol_hold;
	logic [MEAS_W-1:0]   tmo;
	logic                fail;

	always_comb begin
		tol_acq  = per_r >> ACQ_SHIFT;
		tol_hold = per_r >> HOLD_SHIFT;
		tmo      = MEAS_W'(per_r) + MEAS_W'(per_r >> TMO_SHIFT);
		sy_nxt   = sy_r;
		good_nxt = good_r;
		bad_nxt  = bad_r;
		fail     = 1'b0;
		meas_nxt = (meas_r == MEAS_MAX) ? MEAS_MAX : meas_r + 12'h001;
		if (meas_r >= tmo) meas_nxt = '0;
		// restart at one so an edge reads the whole interval it closes
		if (sync_edge) meas_nxt = 12'h001;
		case (sy_r)
			SY_OFF: begin
				good_nxt = '0;
				bad_nxt  = '0;
				if (sync_in_act) sy_nxt = SY_ACQ;
			end
			SY_ACQ: begin
				if (sync_edge && in_win(meas_r, per_r, tol_acq)) begin
					good_nxt = good_r + 2'h1;
					if (good_nxt == ACQ_GOOD) sy_nxt = SY_LOCK;
				end else if (sync_edge || meas_r >= tmo) begin
					good_nxt = '0;
					bad_nxt  = bad_r + 3'h1;
					if (bad_nxt == ACQ_BAD) begin
						fail    = 1'b1;
						bad_nxt = '0;
					end
				end
			end
			SY_LOCK: begin
				good_nxt = '0;
				if ((sync_edge && !in_win(meas_r, per_r, tol_hold)) ||
				    (!sync_edge && meas_r > MEAS_W'(per_r) + MEAS_W'(tol_hold))) begin
					fail   = 1'b1;
					sy_nxt = SY_ACQ;
				end
			end
			default: sy_nxt = SY_OFF;
		endcase
		if (!sync_in_act || st_r == ST_CFG) sy_nxt = SY_OFF;
		fault_nxt = fail || (fault_r && !i_sync_fault_clr);
		evt_nxt   = '0;
		if (sync_edge) evt_nxt[i_sync_loop_sel] = 1'b1;
	end

	assign resync = sync_edge && (sy_r == SY_LOCK) && !i_sync_loop_sel;

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			sy_r    <= SY_OFF;
			meas_r  <= '0;
			good_r  <= '0;
			bad_r   <= '0;
			fault_r <= 1'b0;
			evt_r   <= '0;
		end else begin
			sy_r    <= sy_nxt;
			meas_r  <= meas_nxt;
			good_r  <= good_nxt;
			bad_r   <= bad_nxt;
			fault_r <= fault_nxt;
			evt_r   <= evt_nxt;
		end
	end

	assign o_sync_locked = (sy_r == SY_LOCK);
	assign o_sync_fault  = fault_r;
	assign o_sync_evt    = evt_r;

	// ------------------------------------------------------------
	// sync output phase
	// ------------------------------------------------------------
	logic                sout_r;
	logic                sout_nxt;
	logic                soe_n_r;
	logic                soe_n_nxt;

	always_comb begin
		sout_nxt  = (st_nxt == ST_RUN) && (cnt_nxt >= i_sync_phase);
		soe_n_nxt = !(i_sync_en && i_sync_dir_out && st_nxt != ST_CFG);
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			sout_r  <= 1'b0;
			soe_n_r <= 1'b1;
		end else begin
			sout_r  <= sout_nxt;
			soe_n_r <= soe_n_nxt;
		end
	end

	assign o_multipurpose_sync_pin_out  = sout_r && !soe_n_r;
	assign o_multipurpose_sync_pin_oe_n = soe_n_r;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_no_overlap;
		@(posedge i_mclk) disable iff (!i_rstn)
		!(o_pwm_main && o_pwm_comp);
	endproperty
	a_no_overlap: assert property (p_no_overlap)
		else $error("both gate outputs high");

	property p_hiz_in_cfg;
		@(posedge i_mclk) disable iff (!i_rstn)
		(st_r == ST_CFG) |-> (o_pwm_main_oe_n && o_pwm_comp_oe_n);
	endproperty
	a_hiz_in_cfg: assert property (p_hiz_in_cfg)
		else $error("gate pins driven during configuration");

	property p_idle_low;
		@(posedge i_mclk) disable iff (!i_rstn)
		(st_r == ST_CFG && i_cfg_done && i_loop_assigned) |=>
			(!o_pwm_main_oe_n && !o_pwm_main && !o_pwm_comp);
	endproperty
	a_idle_low: assert property (p_idle_low)
		else $error("assigned outputs not driven low after configuration");

	property p_period_step;
		@(posedge i_mclk) disable iff (!i_rstn)
		(per_r[1:0] == 2'h0) && (per_r >= MIN_PER_TICKS);
	endproperty
	a_period_step: assert property (p_period_step)
		else $error("effective period not a legal step");

	property p_wrap;
		@(posedge i_mclk) disable iff (!i_rstn)
		(st_r == ST_RUN && st_nxt == ST_RUN && !resync && cnt_r == per_r - 11'h001) |=>
			(cnt_r == '0);
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("coarse counter did not wrap at period");

	property p_lock_off;
		@(posedge i_mclk) disable iff (!i_rstn)
		(!i_sync_en || i_sync_dir_out) |=> !o_sync_locked;
	endproperty
	a_lock_off: assert property (p_lock_off)
		else $error("lock shown while sync input inactive");

	property p_sync_phase;
		@(posedge i_mclk) disable iff (!i_rstn)
		(st_r == ST_RUN && !soe_n_r && $stable(i_sync_phase)) |->
			(o_multipurpose_sync_pin_out == ($past(cnt_nxt) >= i_sync_phase));
	endproperty
	a_sync_phase: assert property (p_sync_phase)
		else $error("sync output phase does not follow threshold");

	property p_fault_on_loss;
		@(posedge i_mclk) disable iff (!i_rstn)
		(sy_r == SY_LOCK && sync_edge && !in_win(meas_r, per_r, tol_hold) && sync_in_act
			&& st_r != ST_CFG) |=> (o_sync_fault && !o_sync_locked);
	endproperty
	a_fault_on_loss: assert property (p_fault_on_loss)
		else $error("lock loss did not raise fault");

	property p_priority;
		@(posedge i_mclk) disable iff (!i_rstn)
		(i_sync_pin_sel[1] && !i_sync_pin_sel[0]) |-> (sel_lvl == pin_s2_r[1]);
	endproperty
	a_priority: assert property (p_priority)
		else $error("lowest selected pin not used for sync");

endmodule

// File: verification/hpd_far_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// gate drivers and peer sync source
// ----------------------------------------
module hpd_far_model (
	// clock
	input  wire logic        i_mclk,
	// gate and sync pins from the block
	input  wire logic        i_main,
	input  wire logic        i_main_oe_n,
	input  wire logic        i_comp,
	input  wire logic        i_comp_oe_n,
	input  wire logic        i_sout,
	input  wire logic        i_sout_oe_n,
	// peer source control, interval 0 stops the source
	input  wire logic [7:0]  i_src_mask,
	input  wire logic [7:0]  i_junk_mask,
	input  wire logic [11:0] i_interval,
	// resolved pin levels
	output logic             o_main,
	output logic             o_comp,
	output logic [7:0]       o_pins
);
	logic [11:0] cnt;
	logic        tog;
	logic        m_l;
	logic        c_l;
	logic        pulse;
	initial begin
		cnt = 12'h000;
		tog = 1'b0;
		m_l = 1'b0;
		c_l = 1'b0;
	end
	always @(posedge i_mclk) begin
		tog <= ~tog;
		cnt <= (i_interval == 12'h000 || cnt >= i_interval - 12'h001) ? 12'h000 : cnt + 12'h001;
		if (!i_main_oe_n) m_l <= i_main;
		if (!i_comp_oe_n) c_l <= i_comp;
	end
	// source period is set by the bench, both inside and outside the lock band
	assign pulse = (i_interval != 12'h000) && (cnt < 12'h003);
	// released lines show the inverse of the last driven level
	assign o_main = i_main_oe_n ? ~m_l : i_main;
	assign o_comp = i_comp_oe_n ? ~c_l : i_comp;
	always_comb begin
		o_pins = (i_src_mask & {8{pulse}}) | (i_junk_mask & {8{tog}});
		if (!i_sout_oe_n) o_pins[0] = i_sout;
	end
endmodule

// File: verification/test_hpd_pwm_top.sv
`timescale 1ns/1ps
module test_hpd_pwm_top;
	import hpd_pkg::*;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	typedef struct {
		logic [10:0] req, coarse, per, hi;
		logic [5:0]  fine;
		logic [7:0]  rise, fall;
	} hpd_row_t;
	hpd_row_t    rows[4];
	logic        clk, rstn, cfg_done, assigned, run, s_en, s_out, s_loop, s_clr;
	logic [10:0] per_req, phase;
	logic [7:0]  s_sel, src_mask, junk_mask, pins;
	logic [11:0] interval;
	hpd_edge_t   duty;
	hpd_dt_cfg_t dt_m, dt_c;
	logic        pwm_m, pwm_m_oe_n, pwm_c, pwm_c_oe_n, so, so_oe_n, locked, fault;
	logic        g_main, g_comp;
	logic [1:0]  evt;
	logic [5:0]  fine;
	int          err_total, total_checks, p, h, o, lk, e0, e1, hi_s;
	hpd_pwm_top hpd_pwm_top_i (
		.i_mclk(clk), .i_rstn(rstn), .i_cfg_done(cfg_done),
		.i_loop_assigned(assigned), .i_run(run), .i_period_ticks(per_req),
		.i_duty(duty), .i_dt_main(dt_m), .i_dt_comp(dt_c),
		.i_sync_en(s_en), .i_sync_dir_out(s_out), .i_sync_pin_sel(s_sel),
		.i_sync_loop_sel(s_loop), .i_sync_phase(phase), .i_sync_fault_clr(s_clr),
		.i_sync_pins(pins), .o_multipurpose_sync_pin_out(so),
		.o_multipurpose_sync_pin_oe_n(so_oe_n), .o_pwm_main(pwm_m),
		.o_pwm_main_oe_n(pwm_m_oe_n), .o_pwm_comp(pwm_c), .o_pwm_comp_oe_n(pwm_c_oe_n),
		.o_fine_main(fine), .o_sync_locked(locked), .o_sync_fault(fault), .o_sync_evt(evt)
	);
	hpd_far_model hpd_far_model_i (
		.i_mclk(clk), .i_main(pwm_m), .i_main_oe_n(pwm_m_oe_n), .i_comp(pwm_c),
		.i_comp_oe_n(pwm_c_oe_n), .i_sout(so), .i_sout_oe_n(so_oe_n),
		.i_src_mask(src_mask), .i_junk_mask(junk_mask), .i_interval(interval),
		.o_main(g_main), .o_comp(g_comp), .o_pins(pins)
	);
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %0d seen %0d", nm, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wt(input logic lv);
		int n;
		for (n = 0; n < 6000 && g_main !== lv; n++) @(negedge clk);
		if (n == 6000) chk("edge wait", 0, 1);
	endtask
	task automatic meas(output int pr, output int hh, output int ov);
		logic lo;
		pr = 0;
		hh = 1;
		ov = 0;
		lo = 0;
		wt(1'b0);
		wt(1'b1);
		do begin
			@(negedge clk);
			pr++;
			ov += (g_main === 1'b1 && g_comp === 1'b1);
			if (g_main !== 1'b1) lo = 1;
			else if (!lo) hh++;
		end while (pr < 6000 && !(lo && g_main === 1'b1));
	endtask
	task automatic run_for(input int n);
		lk = 0;
		e0 = 0;
		e1 = 0;
		hi_s = 0;
		repeat (n) begin
			@(negedge clk);
			lk += (locked === 1'b1);
			e0 += (evt[0] === 1'b1);
			e1 += (evt[1] === 1'b1);
			hi_s += (so === 1'b1);
		end
		tick(1);
	endtask
	task automatic clr_fault();
		s_clr = 1;
		tick(1);
		s_clr = 0;
		tick(1);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// clock, watchdog, sequence
	// ----------------------------------------
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	// all tests take about 22000 cycles
	initial begin
		repeat (60000) @(posedge clk);
		err_total++;
		end_sim();
	end
	initial begin
		rows[0] = '{11'h0cb, 11'h032, 11'h0c8, 11'h032, 6'h15, 8'h00, 8'h00};
		rows[1] = '{11'h063, 11'h01e, 11'h064, 11'h01c, 6'h3f, 8'h08, 8'h00};
		rows[2] = '{11'h7ff, 11'h3e8, 11'h7fc, 11'h3e8, 6'h00, 8'hff, 8'hff};
		rows[3] = '{11'h08e, 11'h028, 11'h08c, 11'h029, 6'h2a, 8'h05, 8'h0c};
		err_total = 0;
		total_checks = 0;
		rstn = 0;
		cfg_done = 0;
		assigned = 1;
		run = 1;
		per_req = 11'h0c8;
		duty = '{11'h032, 6'h00};
		dt_m = '0;
		dt_c = '0;
		s_en = 0;
		s_out = 0;
		s_loop = 0;
		s_clr = 0;
		phase = 11'h096;
		s_sel = 8'h06;
		src_mask = 8'h02;
		junk_mask = 8'h04;
		interval = 12'h000;
		tick(3);
		chk("oe_n in reset", {pwm_m_oe_n, pwm_c_oe_n, so_oe_n}, 3'h7);
		rstn = 1;
		tick(4);
		chk("oe_n before config", {pwm_m_oe_n, pwm_c_oe_n}, 2'h3);
		assigned = 0;
		cfg_done = 1;
		tick(4);
		chk("oe_n unassigned", {pwm_m_oe_n, pwm_c_oe_n}, 2'h3);
		run = 0;
		assigned = 1;
		tick(4);
		chk("driven low", {pwm_m_oe_n, pwm_c_oe_n, pwm_m, pwm_c}, 4'h0);
		$display("test reset done");
		run = 1;
		foreach (rows[k]) begin
			tick(1);
			per_req = rows[k].req;
			duty = '{rows[k].coarse, rows[k].fine};
			dt_m = '{rows[k].rise, rows[k].fall};
			dt_c = dt_m;
			meas(p, h, o);
			meas(p, h, o);
			chk("period", p, rows[k].per);
			chk("high time", h, rows[k].hi);
			chk("overlap", o, 0);
			chk("fine code", fine, rows[k].fine);
			$display("test row %0d done", k);
		end
		tick(1);
		per_req = 11'h0c8;
		duty = '{11'h032, 6'h00};
		dt_m = '0;
		dt_c = '0;
		s_en = 1;
		interval = 12'h0c8;
		run_for(2400);
		chk("lock", locked, 1'b1);
		chk("evt loop 0", e0 > 0, 1'b1);
		clr_fault();
		interval = 12'h0dc;
		run_for(2000);
		chk("hold lock", lk, 2000);
		chk("no fault", fault, 1'b0);
		interval = 12'h000;
		run_for(600);
		chk("lost source", {fault, locked}, 2'h2);
		clr_fault();
		chk("fault clear", fault, 1'b0);
		interval = 12'h0dc;
		run_for(2400);
		chk("no lock far", lk, 0);
		clr_fault();
		s_loop = 1;
		tick(1);
		interval = 12'h0c8;
		run_for(2400);
		chk("lock loop 1", locked, 1'b1);
		chk("evt routing", {e0 > 0, e1 > 0}, 2'h1);
		clr_fault();
		interval = 12'h0a0;
		run_for(600);
		chk("lost window", {fault, locked}, 2'h2);
		interval = 12'h0c8;
		run_for(1200);
		chk("relock", locked, 1'b1);
		s_en = 0;
		tick(2);
		chk("lock off disabled", locked, 1'b0);
		$display("test sync input done");
		s_en = 1;
		s_out = 1;
		s_loop = 0;
		interval = 12'h000;
		tick(3);
		chk("lock off output", locked, 1'b0);
		chk("sync pin driven", so_oe_n, 1'b0);
		run_for(400);
		chk("sync out phase", hi_s, 100);
		$display("test sync output done");
		rstn = 0;
		#1;
		chk("oe_n mid reset", {pwm_m_oe_n, pwm_c_oe_n, so_oe_n}, 3'h7);
		tick(2);
		rstn = 1;
		tick(2);
		chk("low after reset", {pwm_m_oe_n, pwm_c_oe_n, pwm_m, pwm_c}, 4'h0);
		$display("test second reset done");
		end_sim();
	end
endmodule
